/* ppfm_cfg.svh */
// offsets, field positions and reset values of the port service and floppy mux block
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH

// register byte offsets on the wishbone slave
`define PPFM_OFF_CMDQ 12'h000
`define PPFM_OFF_DATAQ 12'h400
`define PPFM_OFF_CTRL 12'h404
`define PPFM_OFF_STAT 12'h408
`define PPFM_OFF_PDATA 12'h40c
`define PPFM_OFF_PCTL 12'h410
`define PPFM_OFF_PSTS 12'h414

// control register field positions
`define PPFM_CTL_THR_LSB 0
`define PPFM_CTL_DIR 4
`define PPFM_CTL_DMA 5
`define PPFM_CTL_MASK 6
`define PPFM_CTL_MODE_LO 7
`define PPFM_CTL_MODE_HI 8
`define PPFM_CTL_PWR 9
`define PPFM_CTL_SWEN_LSB 10
`define PPFM_CTL_SWFN 12
`define PPFM_CTL_POL 13
`define PPFM_CTL_WAKE_EN 14
`define PPFM_CTL_MGMT_EN 15
`define PPFM_CTL_RESET 16'h0040

// port control register bits
`define PPFM_PCTL_DIR 5
`define PPFM_PCTL_RESET 6'h04

// readback while the floppy owns the pins
`define PPFM_PCTL_NOCABLE 8'h04
`define PPFM_PSTS_NOCABLE 8'h48

// switch-enable field encodings
`define PPFM_SWEN_OFF 2'h0
`define PPFM_SWEN_SINGLE 2'h1
`define PPFM_SWEN_DUAL 2'h2

`endif

/* ppfm_mux.sv */
// port queue service requests and floppy-on-port pin multiplexer
`timescale 1ns/1ps
`include "ppfm_cfg.svh"

module ppfm_mux
    import ppfm_pkg::*;
#(
    parameter int QDEPTH = 16,
    parameter int LW = 5
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // port queue side
    input wire logic [LW-1:0] queue_level_i,
    input wire logic [7:0] queue_rdata_i,
    output logic queue_wr_o,
    output logic queue_cmd_o,
    output logic [7:0] queue_wdata_o,
    output logic queue_rd_o,
    // port event sources and gated outputs
    input wire logic port_irq_i,
    input wire logic port_smi_i,
    input wire logic port_drq_i,
    output logic irq_o,
    output logic smi_o,
    output logic drq_o,
    output logic svc_o,
    output logic wake_o,
    output logic mgmt_o,
    // switch pin
    input wire logic switch_pin_i,
    // parallel data pins
    input wire logic [7:0] pd_i,
    output logic [7:0] pd_o,
    output logic [7:0] pd_oe_n_o,
    // control pins: strobe, autofeed, init, select-in
    input wire logic [3:0] pc_i,
    output logic [3:0] pc_o,
    output logic [3:0] pc_oe_n_o,
    // status pins: ack, busy, paper-end, select, error
    input wire logic [4:0] ps_i,
    output logic [4:0] ps_o,
    output logic [4:0] ps_oe_n_o,
    // floppy controller outputs
    input wire logic drive_select_zero_n_i,
    input wire logic drive_select_one_n_i,
    input wire logic motor_zero_n_i,
    input wire logic motor_one_n_i,
    input wire logic write_data_n_i,
    input wire logic write_gate_n_i,
    input wire logic density_select_i,
    input wire logic head_select_n_i,
    input wire logic step_direction_n_i,
    input wire logic step_pulse_n_i,
    input wire logic port_drive_selected_i,
    // floppy controller inputs
    output logic index_pulse_n_o,
    output logic track_zero_n_o,
    output logic write_protect_n_o,
    output logic read_data_n_o,
    output logic disk_changed_n_o,
    // native floppy pins
    output logic [9:0] native_pins_o,
    output logic native_pins_oe_n_o
);

    ppfm_state_t st;
    ppfm_state_t nx;

    // effective threshold with sixteen folded onto fifteen
    function automatic logic [LW-1:0] eff_thr(input logic [3:0] f);
        logic [LW-1:0] t;
        t = LW'(f) + LW'(1);
        if (t > LW'(QDEPTH - 1)) begin
            t = LW'(QDEPTH - 1);
        end
        return t;
    endfunction

    // service condition for the live queue level
    function automatic logic svc_cond(input logic [15:0] c, input logic [LW-1:0] lvl);
        logic [LW-1:0] t;
        logic hit;
        t = eff_thr(c[`PPFM_CTL_THR_LSB +: 4]);
        if (c[`PPFM_CTL_DIR]) begin
            hit = lvl >= (LW'(QDEPTH) - t);
        end else begin
            hit = lvl <= t;
        end
        return hit && !c[`PPFM_CTL_MASK] && !c[`PPFM_CTL_DMA];
    endfunction

    logic req;
    logic acc;
    logic fom;
    logic sw_lvl;
    logic sw_ctrl;
    logic want;
    logic want_dual;
    logic [1:0] swen;

    // bus request decode and routing request
    always_comb begin
        req = cyc_i && stb_i;
        acc = req && st.ack;
        fom = st.mst != MX_PORT;
        swen = st.ctl[`PPFM_CTL_SWEN_LSB +: 2];
        sw_lvl = st.stab[17] ^ st.ctl[`PPFM_CTL_POL];
        sw_ctrl = st.ctl[`PPFM_CTL_SWFN] && (swen == `PPFM_SWEN_SINGLE || swen == `PPFM_SWEN_DUAL);
        if (sw_ctrl) begin
            want = !sw_lvl;
            want_dual = swen == `PPFM_SWEN_DUAL;
        end else begin
            want = st.ctl[`PPFM_CTL_MODE_HI] || st.ctl[`PPFM_CTL_MODE_LO];
            want_dual = st.ctl[`PPFM_CTL_MODE_HI];
        end
    end

    // next state
    always_comb begin
        nx = st;
        // bus answer: data and ack together the cycle after the request, drop after
        nx.ack = req && !st.ack;
        nx.q_wr = 1'b0;
        nx.q_cmd = 1'b0;
        nx.q_rd = 1'b0;
        if (req && !st.ack && !we_i) begin
            nx.dat = 32'h0;
            case (adr_i)
                `PPFM_OFF_DATAQ: begin
                    nx.dat = {24'h0, queue_rdata_i};
                    nx.q_rd = 1'b1;
                end
                `PPFM_OFF_CTRL: nx.dat = {16'h0, st.ctl};
                `PPFM_OFF_STAT: begin
                    nx.dat = {21'h0, st.mst, st.stab[17], st.dual, fom, st.svc, 5'(queue_level_i)};
                end
                `PPFM_OFF_PDATA: begin
                    if (fom) begin
                        nx.dat = {24'h0, st.pdata};
                    end else begin
                        nx.dat = {24'h0, st.stab[7:0]};
                    end
                end
                `PPFM_OFF_PCTL: begin
                    if (fom) begin
                        nx.dat = {24'h0, `PPFM_PCTL_NOCABLE};
                    end else begin
                        nx.dat = {26'h0, st.pctl};
                    end
                end
                `PPFM_OFF_PSTS: begin
                    if (fom) begin
                        nx.dat = {24'h0, `PPFM_PSTS_NOCABLE};
                    end else begin
                        nx.dat = {24'h0, ~st.stab[13], st.stab[12], st.stab[14],
                                  st.stab[15], st.stab[16], 3'h0};
                    end
                end
                default: nx.dat = 32'h0;
            endcase
        end
        // writes take effect at the edge where the master sees ack
        if (acc && we_i && sel_i[0]) begin
            case (adr_i)
                `PPFM_OFF_CMDQ: begin
                    nx.q_wr = 1'b1;
                    nx.q_cmd = 1'b1;
                    nx.q_wdat = dat_i[7:0];
                end
                `PPFM_OFF_DATAQ: begin
                    nx.q_wr = 1'b1;
                    nx.q_wdat = dat_i[7:0];
                end
                `PPFM_OFF_PDATA: nx.pdata = dat_i[7:0];
                `PPFM_OFF_PCTL: nx.pctl = dat_i[5:0];
                `PPFM_OFF_CTRL: nx.ctl[7:0] = dat_i[7:0];
                default: nx.pctl = st.pctl;
            endcase
        end
        if (acc && we_i && sel_i[1] && adr_i == `PPFM_OFF_CTRL) begin
            nx.ctl[15:8] = dat_i[15:8];
        end
        // pin synchronisers, a change counts once stages two and three agree
        nx.s1 = {switch_pin_i, ps_i, pc_i, pd_i};
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        nx.stab = ((st.s2 ~^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.stab);
        // switch pin edges
        nx.wake = (nx.stab[17] != st.stab[17]) && st.ctl[`PPFM_CTL_WAKE_EN];
        nx.mgmt = (nx.stab[17] != st.stab[17]) && st.ctl[`PPFM_CTL_MGMT_EN];
        // service request on live level
        nx.svc = svc_cond(st.ctl, queue_level_i);
        nx.irq = (st.svc || port_irq_i) && !fom;
        nx.smi = port_smi_i && !fom;
        nx.drq = port_drq_i && !fom && !st.ctl[`PPFM_CTL_MASK];
        // routing sequencer, always through a released state
        case (st.mst)
            MX_PORT: begin
                if (want) begin
                    nx.mst = MX_TO_FDD;
                end
            end
            MX_TO_FDD: begin
                nx.mst = MX_FDD;
                nx.dual = want_dual;
            end
            MX_FDD: begin
                if (!want || want_dual != st.dual) begin
                    nx.mst = MX_TO_PORT;
                end
            end
            MX_TO_PORT: nx.mst = MX_PORT;
            default: nx.mst = MX_PORT;
        endcase
        // port pin drive released by default, native floppy pins driven
        nx.pd_o = 8'h0;
        nx.pd_oe_n = 8'hff;
        nx.pc_o = 4'h0;
        nx.pc_oe_n = 4'hf;
        nx.ps_o = 5'h0;
        nx.ps_oe_n = 5'h1f;
        nx.fin = 5'h1f;
        nx.nat = {step_pulse_n_i, step_direction_n_i, head_select_n_i, density_select_i,
                  write_gate_n_i, write_data_n_i, motor_one_n_i, motor_zero_n_i,
                  drive_select_one_n_i, drive_select_zero_n_i};
        nx.nat_oe_n = 1'b0;
        case (st.mst)
            MX_PORT: begin
                if (st.ctl[`PPFM_CTL_PWR]) begin
                    nx.pd_o = st.pdata;
                    nx.pd_oe_n = {8{st.pctl[`PPFM_PCTL_DIR]}};
                    nx.pc_o = {~st.pctl[3], st.pctl[2], ~st.pctl[1], ~st.pctl[0]};
                    nx.pc_oe_n = 4'h0;
                end
            end
            MX_FDD: begin
                nx.fin = st.stab[4:0];
                nx.pc_o = {step_pulse_n_i, step_direction_n_i, density_select_i,
                           drive_select_zero_n_i};
                nx.pc_oe_n = {3'h0, !st.dual};
                nx.ps_o = {head_select_n_i, write_gate_n_i, write_data_n_i, motor_one_n_i,
                           drive_select_one_n_i};
                nx.ps_oe_n = 5'h0;
                nx.pd_o = {1'b0, motor_zero_n_i, 6'h0};
                nx.pd_oe_n = {1'b1, !st.dual, 6'h3f};
                nx.nat_oe_n = port_drive_selected_i;
            end
            default: nx.fin = 5'h1f;
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.ctl <= `PPFM_CTL_RESET;
            st.pctl <= `PPFM_PCTL_RESET;
            st.mst <= MX_PORT;
            st.pd_oe_n <= 8'hff;
            st.pc_oe_n <= 4'hf;
            st.ps_oe_n <= 5'h1f;
            st.fin <= 5'h1f;
            st.s1 <= 18'h3ffff;
            st.s2 <= 18'h3ffff;
            st.s3 <= 18'h3ffff;
            st.stab <= 18'h3ffff;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from the state register
    assign dat_o = st.dat;
    assign ack_o = st.ack;
    assign queue_wr_o = st.q_wr;
    assign queue_cmd_o = st.q_cmd;
    assign queue_wdata_o = st.q_wdat;
    assign queue_rd_o = st.q_rd;
    assign irq_o = st.irq;
    assign smi_o = st.smi;
    assign drq_o = st.drq;
    assign svc_o = st.svc;
    assign wake_o = st.wake;
    assign mgmt_o = st.mgmt;
    assign pd_o = st.pd_o;
    assign pd_oe_n_o = st.pd_oe_n;
    assign pc_o = st.pc_o;
    assign pc_oe_n_o = st.pc_oe_n;
    assign ps_o = st.ps_o;
    assign ps_oe_n_o = st.ps_oe_n;
    assign index_pulse_n_o = st.fin[0];
    assign track_zero_n_o = st.fin[1];
    assign write_protect_n_o = st.fin[2];
    assign read_data_n_o = st.fin[3];
    assign disk_changed_n_o = st.fin[4];
    assign native_pins_o = st.nat;
    assign native_pins_oe_n_o = st.nat_oe_n;

    // checks on the service request
    a_mask_blocks_req: assert property (@(posedge clk_i) disable iff (rst_i)
        st.ctl[`PPFM_CTL_MASK] |=> !svc_o && !drq_o)
        else $error("service request while masked");
    a_rev_req_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctl[6:4] == 3'b001 && queue_level_i >= LW'(QDEPTH) - eff_thr(st.ctl[3:0]))
        |=> svc_o)
        else $error("reverse request missing");
    a_fwd_req_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctl[6:4] == 3'b000)
        |=> (svc_o == ($past(queue_level_i) <= eff_thr($past(st.ctl[3:0])))))
        else $error("forward request wrong");
    a_thr_fold: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctl[6:0] == 7'h0f && queue_level_i == LW'(QDEPTH)) |=> !svc_o)
        else $error("threshold sixteen not folded");

    // checks on routing, readback and switch edge events
    a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.mst != MX_PORT) |=> !irq_o && !smi_o && !drq_o)
        else $error("port event while floppy routed");
    a_turn_released: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.mst == MX_TO_FDD || st.mst == MX_TO_PORT)
        |=> pd_oe_n_o == 8'hff && pc_oe_n_o == 4'hf && ps_oe_n_o == 5'h1f)
        else $error("direction change without release");
    a_ctl_nocable: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !st.ack && !we_i && adr_i == `PPFM_OFF_PCTL && st.mst == MX_FDD)
        |=> ack_o && dat_o[7:0] == 8'h04)
        else $error("control readback not cable-absent");
    a_sts_nocable: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !st.ack && !we_i && adr_i == `PPFM_OFF_PSTS && st.mst == MX_FDD)
        |=> ack_o && dat_o[7:0] == 8'h48)
        else $error("status readback not idle pattern");
    a_native_float: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.mst == MX_FDD && port_drive_selected_i) |=> native_pins_oe_n_o)
        else $error("native floppy pins driven");
    a_switch_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctl[`PPFM_CTL_WAKE_EN] && st.s2[17] == st.s3[17] && st.s2[17] != st.stab[17])
        |=> wake_o)
        else $error("switch edge without wake event");

endmodule // ppfm_mux

/* ppfm_pin_partner.sv */
// pin-side partner: floppy drive on data 0..4, printer status, pulled-up lines
`timescale 1ns/1ps
module ppfm_pin_partner (
    // design drive values and enables
    input wire logic [7:0] pd_drv_i,
    input wire logic [7:0] pd_oe_n_i,
    input wire logic [3:0] pc_drv_i,
    input wire logic [3:0] pc_oe_n_i,
    input wire logic [4:0] ps_drv_i,
    input wire logic [4:0] ps_oe_n_i,
    // far-side sources
    input wire logic drive_on_i,
    input wire logic [4:0] drive_stat_i,
    input wire logic [4:0] prn_stat_i,
    // resolved pin levels
    output logic [7:0] pd_o,
    output logic [3:0] pc_o,
    output logic [4:0] ps_o,
    output logic clash_o
);
    logic [7:0] far_pd;

    // attached drive answers on data 0..4, the rest float high
    assign far_pd = drive_on_i ? {3'h7, drive_stat_i} : 8'hff;
    // a driven pin wins, a released one shows the far side or the pull-up
    assign pd_o = (~pd_oe_n_i & pd_drv_i) | (pd_oe_n_i & far_pd);
    assign pc_o = (~pc_oe_n_i & pc_drv_i) | pc_oe_n_i;
    assign ps_o = (~ps_oe_n_i & ps_drv_i) | (ps_oe_n_i & prn_stat_i);
    // design and drive fighting over a drive status line
    assign clash_o = drive_on_i & ~&pd_oe_n_i[4:0];
endmodule // ppfm_pin_partner

/* ppfm_pkg.sv */
// types of the port service and floppy mux block
package ppfm_pkg;

    // pin routing states, gray coded around the loop
    typedef enum logic [1:0] {
        MX_PORT = 2'b00,
        MX_TO_FDD = 2'b01,
        MX_FDD = 2'b11,
        MX_TO_PORT = 2'b10
    } ppfm_mux_t;

    // whole block state
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [15:0] ctl;
        logic [7:0] pdata;
        logic [5:0] pctl;
        logic [17:0] s1;
        logic [17:0] s2;
        logic [17:0] s3;
        logic [17:0] stab;
        ppfm_mux_t mst;
        logic dual;
        logic svc;
        logic irq;
        logic smi;
        logic drq;
        logic wake;
        logic mgmt;
        logic q_wr;
        logic q_cmd;
        logic q_rd;
        logic [7:0] q_wdat;
        logic [7:0] pd_o;
        logic [7:0] pd_oe_n;
        logic [3:0] pc_o;
        logic [3:0] pc_oe_n;
        logic [4:0] ps_o;
        logic [4:0] ps_oe_n;
        logic [4:0] fin;
        logic [9:0] nat;
        logic nat_oe_n;
    } ppfm_state_t;

endpackage

/* tb.sv */
// self-checking bench of the port service and floppy mux block
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
`define TB_CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb import ppfm_pkg::*; ;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'h3;
    logic [31:0] wdat = 32'h0, dat_o, q;
    logic ack, qwr, qcmd, qpop, irq, smi, drq, svc, wake, mgmt, nat_oe_n, clash;
    logic [4:0] lvl = 5'h0;
    logic [7:0] qrd = 8'h96, qwd, pd_i, pd_o, pd_oe_n;
    logic pirq = 1'b0, psmi = 1'b0, pdrq = 1'b0, sw = 1'b1, psel = 1'b0, drv_on = 1'b0;
    logic [9:0] fv = 10'h2d6, nat;
    logic [3:0] pc_i, pc_o, pc_oe_n;
    logic [4:0] ps_i, ps_o, ps_oe_n, fin;
    logic [8:0] last_wr = 9'h0;
    logic clash_seen = 1'b0;
    int bad_count = 0, n_tests = 0, wr_cnt = 0, rd_cnt = 0, wk_cnt = 0, mg_cnt = 0;
    // {expected request, queue level, setup word}
    logic [21:0] svc_tab [12] = '{22'h2c000b, 22'h0d000b, 22'h24001b, 22'h03001b,
        22'h2f000f, 22'h10000f, 22'h21001f, 22'h00001f, 22'h210000, 22'h020000,
        22'h00004b, 22'h00002b};
    // {expected dual and routed, switch level, setup word}
    logic [18:0] sw_tab [6] = '{19'h2d600, 19'h1d600, 19'h3f600, 19'h7fa00, 19'h1f200,
        19'h0f200};

    ppfm_mux i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
        .queue_level_i(lvl), .queue_rdata_i(qrd), .queue_wr_o(qwr), .queue_cmd_o(qcmd),
        .queue_wdata_o(qwd), .queue_rd_o(qpop),
        .port_irq_i(pirq), .port_smi_i(psmi), .port_drq_i(pdrq), .irq_o(irq),
        .smi_o(smi), .drq_o(drq), .svc_o(svc), .wake_o(wake), .mgmt_o(mgmt),
        .switch_pin_i(sw), .pd_i(pd_i), .pd_o(pd_o), .pd_oe_n_o(pd_oe_n),
        .pc_i(pc_i), .pc_o(pc_o), .pc_oe_n_o(pc_oe_n), .ps_i(ps_i), .ps_o(ps_o),
        .ps_oe_n_o(ps_oe_n), .drive_select_zero_n_i(fv[0]), .drive_select_one_n_i(fv[1]),
        .motor_zero_n_i(fv[2]), .motor_one_n_i(fv[3]), .write_data_n_i(fv[4]),
        .write_gate_n_i(fv[5]), .density_select_i(fv[6]), .head_select_n_i(fv[7]),
        .step_direction_n_i(fv[8]), .step_pulse_n_i(fv[9]), .port_drive_selected_i(psel),
        .index_pulse_n_o(fin[0]), .track_zero_n_o(fin[1]), .write_protect_n_o(fin[2]),
        .read_data_n_o(fin[3]), .disk_changed_n_o(fin[4]), .native_pins_o(nat),
        .native_pins_oe_n_o(nat_oe_n)
    );

    ppfm_pin_partner i_far (
        .pd_drv_i(pd_o), .pd_oe_n_i(pd_oe_n), .pc_drv_i(pc_o), .pc_oe_n_i(pc_oe_n),
        .ps_drv_i(ps_o), .ps_oe_n_i(ps_oe_n), .drive_on_i(drv_on), .drive_stat_i(5'h15),
        .prn_stat_i(5'h0a), .pd_o(pd_i), .pc_o(pc_i), .ps_o(ps_i), .clash_o(clash)
    );

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // pulse and contention monitors
    always @(posedge clk_i) begin
        if (qwr === 1'b1) begin
            wr_cnt++;
            last_wr = {qcmd, qwd};
        end
        if (qpop === 1'b1) rd_cnt++;
        if (wake === 1'b1) wk_cnt++;
        if (mgmt === 1'b1) mg_cnt++;
        if (clash === 1'b1) clash_seen = 1'b1;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: no acknowledge", $time);
            finish_test();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `PPFM_OFF_CTRL, 0);
        `TB_CHK({q[15:0], svc}, {`PPFM_CTL_RESET, 1'b0})
        // data push, command push, pop, unmapped read
        wb(1'b1, `PPFM_OFF_DATAQ, 32'h5a);
        wb(1'b1, `PPFM_OFF_CMDQ, 32'hc3);
        wb(1'b0, `PPFM_OFF_DATAQ, 0);
        `TB_CHK(q[7:0], qrd)
        wb(1'b0, 12'h7fc, 0);
        `TB_CHK(q, 32'h0)
        `TB_CHK({wr_cnt[3:0], rd_cnt[3:0], last_wr}, {8'h21, 9'h1c3})
        // service request against live level, both directions
        for (int i = 0; i < 12; i++) begin
            wb(1'b1, `PPFM_OFF_CTRL, {16'h0, svc_tab[i][15:0]});
            lvl <= svc_tab[i][20:16];
            repeat (3) @(posedge clk_i);
            `TB_CHK({svc, irq}, {2{svc_tab[i][21]}})
        end
        // port events pass in normal mode, then single drive routing
        pirq <= 1'b1;
        psmi <= 1'b1;
        pdrq <= 1'b1;
        wb(1'b1, `PPFM_OFF_CTRL, 32'h0200);
        wb(1'b1, `PPFM_OFF_PDATA, 32'ha5);
        `TB_CHK({irq, smi, drq}, 3'h7)
        wb(1'b1, `PPFM_OFF_CTRL, 32'h0080);
        repeat (3) @(posedge clk_i);
        drv_on <= 1'b1;
        repeat (6) @(posedge clk_i);
        `TB_CHK({irq, smi, drq, nat_oe_n, nat}, {4'h0, fv})
        `TB_CHK({ps_oe_n, ps_o}, {5'h0, fv[7], fv[5], fv[4], fv[3], fv[1]})
        `TB_CHK({pc_oe_n, pc_o[3:1]}, {4'h1, fv[9], fv[8], fv[6]})
        `TB_CHK({pd_oe_n[6], pd_oe_n[4:0], fin}, {6'h3f, 5'h15})
        wb(1'b0, `PPFM_OFF_PDATA, 0);
        `TB_CHK(q[7:0], 8'ha5)
        wb(1'b0, `PPFM_OFF_PCTL, 0);
        `TB_CHK(q[7:0], `PPFM_PCTL_NOCABLE)
        wb(1'b0, `PPFM_OFF_PSTS, 0);
        `TB_CHK(q[7:0], `PPFM_PSTS_NOCABLE)
        wb(1'b0, `PPFM_OFF_STAT, 0);
        `TB_CHK(q[7:6], 2'h1)
        // dual drive routing with the drive selected on the port
        psel <= 1'b1;
        fv <= ~fv;
        wb(1'b1, `PPFM_OFF_PDATA, 32'h3c);
        wb(1'b1, `PPFM_OFF_CTRL, 32'h0100);
        repeat (10) @(posedge clk_i);
        `TB_CHK({pc_oe_n, pc_o}, {4'h0, fv[9], fv[8], fv[6], fv[0]})
        `TB_CHK({pd_oe_n[6], pd_o[6]}, {1'b0, fv[2]})
        `TB_CHK({irq, smi, drq, nat_oe_n}, 4'h1)
        wb(1'b0, `PPFM_OFF_PDATA, 0);
        `TB_CHK(q[7:0], 8'h3c)
        // back to the normal port, then port powered off
        drv_on <= 1'b0;
        wb(1'b1, `PPFM_OFF_CTRL, 32'h0200);
        repeat (8) @(posedge clk_i);
        `TB_CHK({irq, smi, drq, pc_oe_n, pd_oe_n, pd_o, fin}, {7'h70, 16'h003c, 5'h1f})
        // normal port readback of status pins and control register
        wb(1'b0, `PPFM_OFF_PSTS, 0);
        `TB_CHK(q[7:0], 8'h10)
        wb(1'b1, `PPFM_OFF_PCTL, 32'h2a);
        wb(1'b0, `PPFM_OFF_PCTL, 0);
        `TB_CHK(q[7:0], 8'h2a)
        wb(1'b1, `PPFM_OFF_CTRL, 32'h0000);
        repeat (3) @(posedge clk_i);
        `TB_CHK(pd_oe_n, 8'hff)
        // switch pin routing, polarity, field decode and edge events
        pirq <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, `PPFM_OFF_CTRL, {16'h0, sw_tab[i][15:0]});
            sw <= sw_tab[i][16];
            repeat (8) @(posedge clk_i);
            wb(1'b0, `PPFM_OFF_STAT, 0);
            `TB_CHK({q[7] & q[6], q[6]}, sw_tab[i][18:17])
        end
        // host bursts: drain a full reverse queue, then fill an empty forward one
        wb(1'b1, `PPFM_OFF_CTRL, 32'h001b);
        lvl <= 5'h10;
        for (int i = 15; i >= 0; i--) begin
            wb(1'b0, `PPFM_OFF_DATAQ, 0);
            lvl <= 5'(i);
            repeat (2) @(posedge clk_i);
            `TB_CHK({q[7:0], svc}, {qrd, i >= 4})
        end
        wb(1'b1, `PPFM_OFF_CTRL, 32'h000b);
        for (int i = 1; i <= 16; i++) begin
            wb(1'b1, `PPFM_OFF_DATAQ, i);
            lvl <= 5'(i);
            repeat (2) @(posedge clk_i);
            `TB_CHK(svc, i <= 12)
        end
        `TB_CHK({wr_cnt[7:0], rd_cnt[7:0], last_wr}, {8'd18, 8'd17, 9'h010})
        `TB_CHK({wk_cnt[3:0], mg_cnt[3:0], clash_seen}, {8'h33, 1'b0})
        finish_test();
    end
endmodule // tb
